// >>> rtl/link_startup_pkg.sv
// Constants for the deserializer link startup sequencer.
// Assumes a 40 MHz reference clock; times are converted to cycle counts here.
package link_startup_pkg;
	// Reference clock period in picoseconds.
	localparam int unsigned CLK_PERIOD_PS    = 25000;
	// Control channel blackout after a late power-up, in microseconds.
	localparam int unsigned PWRUP_HOLD_US    = 2000;
	// Reverse channel blackout after a serial link start or stop, in microseconds.
	localparam int unsigned REV_HOLD_US      = 350;
	// Least waits round up to whole cycles.
	localparam int unsigned PWRUP_HOLD_CYC   = (PWRUP_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned REV_HOLD_CYC     = (REV_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Width of the shared blackout counter.
	localparam int unsigned HOLD_W           = 17;
	localparam logic [HOLD_W-1:0] HOLD_ZERO  = 17'h00000;
	localparam logic [HOLD_W-1:0] HOLD_ONE   = 17'h00001;
	// Defaults phase length: the late power-up strap must cross both synchroniser
	// flops before it is judged, so the phase lasts one cycle per flop plus one.
	localparam logic [1:0] DFLT_LAST         = 2'h2;
	localparam logic [1:0] DFLT_ZERO         = 2'h0;
	localparam logic [1:0] DFLT_ONE          = 2'h1;
	// Register map, byte offsets.
	localparam logic [3:0] ADDR_CTRL         = 4'h0;
	localparam logic [3:0] ADDR_STATUS       = 4'h4;
	// Control register field positions.
	localparam int unsigned CTRL_DRS         = 0;
	localparam int unsigned CTRL_BWS         = 1;
	localparam int unsigned CTRL_ECC         = 2;
	localparam int unsigned CTRL_W           = 3;
	// Control register reset value: link format at defaults.
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
	// Status register field positions.
	localparam int unsigned ST_CC_READY      = 0;
	localparam int unsigned ST_VIDEO_LOCK    = 1;
	localparam int unsigned ST_CFG_LOCK      = 2;
	localparam int unsigned ST_STATE_LO      = 4;
	localparam logic [31:0] WORD_ZERO        = 32'h00000000;
	// Link acquisition states.
	typedef enum logic [2:0] {
		ST_DEFAULTS,
		ST_IDLE,
		ST_CFG_ACQ,
		ST_CFG_LOCKED,
		ST_VID_ACQ,
		ST_VID_LOCKED
	} link_state_t;
endpackage : link_startup_pkg

// >>> rtl/link_startup.sv
// Deserializer-side link startup sequencer: default load, lock tracking, control gating.
// Assumes link activity and lock detect come from the analog front end, asynchronous.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module link_startup
	import link_startup_pkg::*;
#(
	parameter int unsigned PWRUP_HOLD = PWRUP_HOLD_CYC,	// Late power-up blackout, cycles.
	parameter int unsigned REV_HOLD   = REV_HOLD_CYC	// Start/stop blackout, cycles.
) (
	input  wire logic              ref_clk,	// System clock, 40 MHz.
	input  wire logic              arst_n,	// Asynchronous reset, active low.
	input  wire logic              clk_en,	// Freezes all state while low.
	input  wire logic              late_pwrup,	// Serializer was already up at power-up.
	input  wire logic              cfg_link_seen,	// Front end sees a config-link signal.
	input  wire logic              video_seen,	// Front end sees a video signal.
	input  wire logic              rx_lock_det,	// Front end word alignment found.
	input  wire logic [3:0]        reg_addr,	// Register byte address.
	input  wire logic [31:0]       reg_wdata,	// Register write data.
	input  wire logic              reg_wr,	// Write strobe.
	input  wire logic              reg_rd,	// Read strobe.
	output logic      [31:0]       reg_rdata,	// Read data, one cycle after strobe.
	output logic      [CTRL_W-1:0] link_fmt,	// Data rate, width, correction selects.
	output logic                   cc_ready,	// Control channel may carry transactions.
	output logic                   video_lock,	// Lock indication, video only.
	output logic                   deser_en	// Deserialized parallel data valid.
);
	// Synchronisers for asynchronous front-end levels.
	logic [1:0] s_cfg_ff, s_vid_ff, s_lock_ff, s_late_ff;
	logic [1:0] nxt_s_cfg, nxt_s_vid, nxt_s_lock, nxt_s_late;
	// Main state and registers.
	link_state_t       state_ff, nxt_state;
	logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;	// Link format bits.
	logic [HOLD_W-1:0] hold_ff, nxt_hold;	// Control channel blackout count.
	logic              vid_prev_ff, nxt_vid_prev;	// Previous video-active flag.
	logic [1:0]        dflt_cnt_ff, nxt_dflt_cnt;	// Cycles spent loading defaults.
	logic [31:0]       rdata_ff, nxt_rdata;	// Read data register.
	logic              cfg_s, vid_s, lock_s, video_act;

	// Only the second flop of each synchroniser is read.
	assign cfg_s  = s_cfg_ff[1];
	assign vid_s  = s_vid_ff[1];
	assign lock_s = s_lock_ff[1];
	// Video link counts as started in acquire or locked states.
	assign video_act = (state_ff == ST_VID_ACQ) || (state_ff == ST_VID_LOCKED);

	// Synchroniser next values.
	always_comb begin
		nxt_s_cfg  = {s_cfg_ff[0], cfg_link_seen};
		nxt_s_vid  = {s_vid_ff[0], video_seen};
		nxt_s_lock = {s_lock_ff[0], rx_lock_det};
		nxt_s_late = {s_late_ff[0], late_pwrup};
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_cfg_ff  <= 2'h0;
			s_vid_ff  <= 2'h0;
			s_lock_ff <= 2'h0;
			s_late_ff <= 2'h0;
		end else if (clk_en) begin
			s_cfg_ff  <= nxt_s_cfg;
			s_vid_ff  <= nxt_s_vid;
			s_lock_ff <= nxt_s_lock;
			s_late_ff <= nxt_s_late;
		end
	end

	// Link state machine. Video always wins over the config link, so a serializer
	// that switches to video mid-configuration drops the config lock at once.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_DEFAULTS: begin
				// Leaving early would judge the strap while its synchroniser still
				// holds the reset value, and a late power-up would go unnoticed.
				if (dflt_cnt_ff == DFLT_LAST) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_IDLE, ST_CFG_ACQ, ST_CFG_LOCKED: begin
				if (vid_s) begin
					nxt_state = ST_VID_ACQ;
				end else if (!cfg_s) begin
					nxt_state = ST_IDLE;
				end else if (lock_s) begin
					nxt_state = ST_CFG_LOCKED;
				end else begin
					nxt_state = ST_CFG_ACQ;
				end
			end
			ST_VID_ACQ, ST_VID_LOCKED: begin
				if (!vid_s) begin
					nxt_state = cfg_s ? ST_CFG_ACQ : ST_IDLE;
				end else if (lock_s) begin
					nxt_state = ST_VID_LOCKED;
				end else begin
					nxt_state = ST_VID_ACQ;
				end
			end
			default: begin
				nxt_state = ST_DEFAULTS;
			end
		endcase
	end

	// Blackout counter: loaded by the late power-up strap while defaults load,
	// reloaded on every video start or stop. A lower count never shortens a longer one.
	always_comb begin
		nxt_vid_prev = video_act;
		nxt_hold     = hold_ff;
		nxt_dflt_cnt = DFLT_ZERO;
		// Count the defaults cycles so the strap is seen through both flops.
		if ((state_ff == ST_DEFAULTS) && (dflt_cnt_ff != DFLT_LAST)) begin
			nxt_dflt_cnt = dflt_cnt_ff + DFLT_ONE;
		end
		if (state_ff == ST_DEFAULTS) begin
			nxt_hold = s_late_ff[1] ? HOLD_W'(PWRUP_HOLD) : HOLD_ZERO;
		end else if ((video_act != vid_prev_ff) && (hold_ff <= HOLD_W'(REV_HOLD))) begin
			nxt_hold = HOLD_W'(REV_HOLD);
		end else if (hold_ff != HOLD_ZERO) begin
			nxt_hold = hold_ff - HOLD_ONE;
		end
	end

	// Register file: control writes land only after defaults are loaded.
	always_comb begin
		nxt_ctrl  = ctrl_ff;
		nxt_rdata = WORD_ZERO;
		if (reg_wr && (state_ff != ST_DEFAULTS)) begin
			if (reg_addr == ADDR_CTRL) begin
				nxt_ctrl = reg_wdata[CTRL_W-1:0];
			end
		end
		if (reg_rd) begin
			if (reg_addr == ADDR_CTRL) begin
				nxt_rdata[CTRL_W-1:0] = ctrl_ff;
			end else if (reg_addr == ADDR_STATUS) begin
				nxt_rdata[ST_CC_READY]   = cc_ready;
				nxt_rdata[ST_VIDEO_LOCK] = video_lock;
				nxt_rdata[ST_CFG_LOCK]   = (state_ff == ST_CFG_LOCKED);
				nxt_rdata[ST_STATE_LO +: 3] = state_ff;
			end else begin
				nxt_rdata = WORD_ZERO;	// Unmapped reads return zero.
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff    <= ST_DEFAULTS;
			ctrl_ff     <= CTRL_RESET;
			hold_ff     <= HOLD_ZERO;
			vid_prev_ff <= 1'b0;
			rdata_ff    <= WORD_ZERO;
			dflt_cnt_ff <= DFLT_ZERO;
		end else if (clk_en) begin
			state_ff    <= nxt_state;
			ctrl_ff     <= nxt_ctrl;
			hold_ff     <= nxt_hold;
			vid_prev_ff <= nxt_vid_prev;
			rdata_ff    <= nxt_rdata;
			dflt_cnt_ff <= nxt_dflt_cnt;
		end
	end

	// Outputs. Control channel needs a locked link and an expired blackout.
	assign cc_ready   = ((state_ff == ST_CFG_LOCKED) || (state_ff == ST_VID_LOCKED))
	                    && (hold_ff == HOLD_ZERO);
	assign video_lock = (state_ff == ST_VID_LOCKED);
	assign deser_en   = (state_ff == ST_VID_LOCKED);
	assign link_fmt   = ctrl_ff;
	assign reg_rdata  = rdata_ff;

	// Assertions.
	sequence vid_edge_s;
		video_act != vid_prev_ff;
	endsequence

	cc_needs_link_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		cc_ready |-> (state_ff == ST_CFG_LOCKED || state_ff == ST_VID_LOCKED))
		else $error("Control channel ready without a locked link.");
	pwrup_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && state_ff == ST_DEFAULTS && s_late_ff[1]) |=> hold_ff == HOLD_W'(PWRUP_HOLD))
		else $error("Power-up blackout not loaded.");
	defaults_first_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(state_ff == ST_DEFAULTS) |=> ctrl_ff == CTRL_RESET)
		else $error("Control written before defaults loaded.");
	cfg_lock_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && state_ff == ST_CFG_ACQ && cfg_s && lock_s && !vid_s) |=> state_ff == ST_CFG_LOCKED)
		else $error("Config link lock not taken.");
	lose_lock_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && state_ff == ST_VID_LOCKED && vid_s && !lock_s) |=> state_ff == ST_VID_ACQ)
		else $error("Lock loss not followed.");
	video_wins_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && state_ff == ST_CFG_LOCKED && vid_s) |=> state_ff == ST_VID_ACQ)
		else $error("Video did not override config link.");
	video_relock_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(clk_en && state_ff == ST_VID_ACQ && vid_s && lock_s) |=> video_lock && deser_en)
		else $error("Video lock not asserted.");
	lock_video_only_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		video_lock |-> video_act && !(state_ff == ST_CFG_LOCKED))
		else $error("Lock shown without video link.");
	rev_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		((clk_en && state_ff != ST_DEFAULTS) and vid_edge_s) |=> (hold_ff >= HOLD_W'(REV_HOLD) && !cc_ready))
		else $error("Reverse channel blackout missing.");
endmodule : link_startup
`default_nettype wire

// >>> tb/serializer_model.sv
// Remote serializer seen from the deserializer's analog front end.
// Assumes the bench commands link start, video start and lock, in ref_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module serializer_model (
	input  wire logic ref_clk,       // Bench clock.
	input  wire logic cfg_on,        // Configuration link wanted.
	input  wire logic vid_on,        // Video serializing wanted.
	input  wire logic lock_ok,       // Word alignment achievable.
	output var  logic cfg_link_seen, // Configuration link present.
	output var  logic video_seen,    // Video signal present.
	output var  logic rx_lock_det    // Alignment found.
);
	initial begin
		cfg_link_seen = 1'b0;
		video_seen = 1'b0;
		rx_lock_det = 1'b0;
	end
	// Alignment exists only while some link is on, so lock never shows on a dead cable.
	always @(posedge ref_clk) begin
		cfg_link_seen <= cfg_on;
		video_seen <= vid_on;
		rx_lock_det <= lock_ok & (cfg_on | vid_on);
	end
endmodule : serializer_model
`default_nettype wire

// >>> tb/link_startup_tb_top.sv
// Bench for the link startup sequencer with a behavioural remote serializer.
// Assumes short blackout parameters so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module link_startup_tb_top;
	import link_startup_pkg::*;
	logic ref_clk = 1'b0, arst_n = 1'b0, cfg_on = 1'b0, vid_on = 1'b0, lock_ok = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, cc_ready, video_lock, deser_en;
	logic cfg_link_seen, video_seen, rx_lock_det;
	logic clk_en = 1'b1;
	logic late_pwrup = 1'b0;
	logic [CTRL_W-1:0] link_fmt;
	int fails = 0, total_checks = 0, cycles = 0;
	link_startup #(.PWRUP_HOLD(20), .REV_HOLD(10)) link_startup_inst (.ref_clk(ref_clk),
		.arst_n(arst_n), .clk_en(clk_en), .late_pwrup(late_pwrup), .cfg_link_seen(cfg_link_seen),
		.video_seen(video_seen), .rx_lock_det(rx_lock_det), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.link_fmt(link_fmt), .cc_ready(cc_ready), .video_lock(video_lock), .deser_en(deser_en));
	serializer_model serializer_model_inst (.ref_clk(ref_clk), .cfg_on(cfg_on), .vid_on(vid_on),
		.lock_ok(lock_ok), .cfg_link_seen(cfg_link_seen), .video_seen(video_seen),
		.rx_lock_det(rx_lock_det));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	// A hang is cut short well beyond the 150 or so cycles the scenarios need.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so they are sampled there.
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk("read data", reg_rdata, exp);
	endtask : rd
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle
	// Defaults after reset, control channel closed until a link exists.
	task automatic t_defaults();
		chk("cc_ready idle", cc_ready, 1'b0);
		chk("link_fmt default", link_fmt, CTRL_RESET);
		rd(ADDR_STATUS, 32'h00000010);
		rd(4'hc, WORD_ZERO);
	endtask : t_defaults
	// Configuration link lock, format write, lock loss and relock.
	task automatic t_cfg_link();
		cfg_on <= 1'b1;
		lock_ok <= 1'b1;
		settle(6);
		chk("cc_ready cfg", cc_ready, 1'b1);
		chk("video_lock cfg", video_lock, 1'b0);
		rd(ADDR_STATUS, 32'h00000035);
		wr(ADDR_CTRL, 32'h00000002);
		wr(ADDR_CTRL, 32'h00000006);
		wr(4'h8, 32'h00000001);
		settle(0);
		chk("link_fmt", link_fmt, 3'h6);
		lock_ok <= 1'b0;
		settle(6);
		chk("cc_ready lost", cc_ready, 1'b0);
		lock_ok <= 1'b1;
		settle(6);
		chk("cc_ready relock", cc_ready, 1'b1);
	endtask : t_cfg_link
	// Video start and stop, each followed by a reverse channel blackout.
	task automatic t_video();
		vid_on <= 1'b1;
		settle(6);
		chk("video_lock", video_lock, 1'b1);
		chk("deser_en", deser_en, 1'b1);
		chk("cc_ready start", cc_ready, 1'b0);
		settle(12);
		chk("cc_ready after", cc_ready, 1'b1);
		vid_on <= 1'b0;
		settle(6);
		chk("video_lock stop", video_lock, 1'b0);
		chk("cc_ready stop", cc_ready, 1'b0);
		settle(12);
		chk("cc_ready back", cc_ready, 1'b1);
	endtask : t_video
	// Camera use: reset again with the serializer already up and serializing.
	task automatic t_camera();
		@(posedge ref_clk);
		arst_n <= 1'b0;
		late_pwrup <= 1'b1;
		cfg_on <= 1'b0;
		vid_on <= 1'b1;
		settle(2);
		chk("cc_ready in reset", cc_ready, 1'b0);
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		settle(10);
		chk("video_lock camera", video_lock, 1'b1);
		chk("cc_ready late pwrup", cc_ready, 1'b0);
		settle(16);
		chk("cc_ready late done", cc_ready, 1'b1);
		rd(ADDR_STATUS, 32'h00000053);
		wr(ADDR_CTRL, 32'h00000002);
		settle(0);
		chk("link_fmt camera", link_fmt, 3'h2);
		lock_ok <= 1'b0;
		settle(6);
		chk("video_lock lost", video_lock, 1'b0);
		lock_ok <= 1'b1;
		settle(6);
		chk("video_lock relock", video_lock, 1'b1);
		chk("cc_ready relock cam", cc_ready, 1'b1);
	endtask : t_camera
	// Clock enable low freezes state and refuses writes; running again catches up.
	task automatic t_freeze();
		@(posedge ref_clk);
		clk_en <= 1'b0;
		lock_ok <= 1'b0;
		settle(8);
		chk("video_lock frozen", video_lock, 1'b1);
		wr(ADDR_CTRL, WORD_ZERO);
		settle(0);
		chk("link_fmt frozen", link_fmt, 3'h2);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		settle(6);
		chk("video_lock thawed", video_lock, 1'b0);
		lock_ok <= 1'b1;
		settle(6);
		chk("video_lock again", video_lock, 1'b1);
	endtask : t_freeze
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (5) @(posedge ref_clk);
		#1 chk("lock in reset", video_lock, 1'b0);
		@(posedge ref_clk);
		arst_n <= 1'b1;
		settle(3);
		t_defaults();
		t_cfg_link();
		t_video();
		t_camera();
		t_freeze();
		wrap_up();
	end
endmodule : link_startup_tb_top
`default_nettype wire
